// file: core/dma_control_status_logic.sv
// DMA control and status logic: registers, bandwidth sharing, arbitration.
// How it works
// - Bandwidth select gives DMA 2/8, 2/4, 2/3, all.
// - CPU cycle between blocks of pending channels.
// - Run bits gate channel transfers; reset clears.
// - One channel moves a unit at a time.
// - Interrupt enables gate done interrupts; reset clears.
// - Priority one: interrupt waits for transfer end.
// - Priority zero: interrupt after unit, clears runs.
// - Added latency at most two/four cycles.
// - Ranking is fixed, channel 0 first, whatever the priority bit.
// - Loop block end: flag, clear count, restart.
// - Non-loop block end: flag, clear count, stop.
// - CPU cycle before each new loop.
// - Wait enable keeps transfers in wait.
// - Suspended transfer resumes only with priority one.
// - Done flag sets at completion, drives interrupt.
// - Done flag clears by read then zero write.
// - Eight software bits act as service requests.
// - Software bit n serves source code n.
// - Software bit reads one while transfer active.
module dma_control_status_logic (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // AXI4-Lite write address and data.
  input wire logic [dma_ctl_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response.
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read.
  input wire logic [dma_ctl_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Peripheral service requests, from outside this clock domain.
  input wire logic [dma_ctl_pkg::NUM_SRC-1:0] periph_req,
  // Channel datapath.
  input wire logic [dma_ctl_pkg::NUM_CH-1:0][2:0] transfer_source_select,
  input wire logic [dma_ctl_pkg::NUM_CH-1:0] chan_word_mode,
  input wire logic [dma_ctl_pkg::NUM_CH-1:0][7:0] chan_byte_count,
  input wire logic [dma_ctl_pkg::NUM_CH-1:0][7:0] chan_block_length,
  output logic [dma_ctl_pkg::NUM_CH-1:0] chan_active,
  output logic [dma_ctl_pkg::NUM_CH-1:0] chan_step,
  output logic [dma_ctl_pkg::NUM_CH-1:0] chan_count_clear,
  output logic dma_bus_own,
  // CPU side.
  input wire logic cpu_irq_req,
  input wire logic cpu_wait,
  output logic cpu_irq_ack,
  output logic dma_irq
);

  localparam int NC = dma_ctl_pkg::NUM_CH;
  localparam int NS = dma_ctl_pkg::NUM_SRC;

  typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_GAP} seq_e;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] ctrl_r; // Channel enable and bandwidth register.
  logic [7:0] stat_r; // Priority, loop and wait enable bits; done bits come from the bank.
  logic [7:0] soft_r; // Software request bits.
  logic aw_full_r; // Write address captured.
  logic w_full_r; // Write data captured.
  logic [dma_ctl_pkg::ADDR_W-1:0] waddr_r; // Captured write address.
  logic [7:0] wbyte_r; // Captured low data byte.
  logic wstrb0_r; // Captured strobe of the low byte lane.
  logic bvalid_r; // Write response pending.
  logic [1:0] bresp_r; // Write response code.
  logic rvalid_r; // Read data pending.
  logic [31:0] rdata_r; // Read data.
  logic [1:0] rresp_r; // Read response code.
  logic [NS-1:0] sync1_r; // First synchroniser stage.
  logic [NS-1:0] sync2_r; // Second synchroniser stage.
  logic [NS-1:0] sync3_r; // Third synchroniser stage.
  logic [NS-1:0] periph_r; // Filtered peripheral requests.
  seq_e state_r; // Sequencer state.
  logic [3:0] cyc_r; // Cycles left in the current unit or gap.
  logic [NC-1:0] active_r; // One-hot channel owning the bus.
  logic [NC-1:0] step_r; // Unit moved, count advances.
  logic [NC-1:0] clear_r; // Block length reached, count clears.
  logic ack_r; // Interrupt recognised.
  logic wait_d_r; // Wait input one cycle ago.
  logic susp_r; // A pending transfer was held off by wait mode.
  logic fire_w; // Write address and data both held.
  logic [NC-1:0] run; // Run bits.
  logic [NC-1:0] irq_en; // Interrupt enables.
  logic [NC-1:0] loop_en; // Loop enables.
  logic prio; // Interrupt priority select.
  logic wait_en; // Wait operation enable.
  logic [NS-1:0] req_all; // Hardware and software service requests.
  logic [NC-1:0] pending; // Enabled channels with a live request.
  logic [NC-1:0] pick; // Winner of the channel ranking.
  logic hold; // New units are held off.
  logic may_start; // The sequencer is at a point where a unit may begin.
  logic unit_end; // Last cycle of a unit.
  logic blk_end; // The unit ending now reaches the block length.
  logic [3:0] gap; // CPU cycles after the unit ending now.
  logic recog; // Interrupt may be recognised now.
  logic [NC-1:0] hw_run_clr; // Run bits cleared by hardware this cycle.
  logic [NS-1:0] soft_clr; // Software bits cleared by hardware this cycle.
  logic [NC-1:0] done_set; // Completion events for the flag bank.

  done_flag_if #(.N(NC)) dif ();

  // ****************************************************************
  // Register fields
  // ****************************************************************
  // Unpack per-channel fields from the packed registers.
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      run[c] = ctrl_r[dma_ctl_pkg::RUN_POS0 + dma_ctl_pkg::CH_STRIDE * c];
      irq_en[c] = ctrl_r[dma_ctl_pkg::IRQEN_POS0 + dma_ctl_pkg::CH_STRIDE * c];
      loop_en[c] = stat_r[dma_ctl_pkg::LOOP_POS0 + c];
    end
  end
  assign prio = stat_r[dma_ctl_pkg::PRIO_POS];
  assign wait_en = stat_r[dma_ctl_pkg::WAITEN_POS];

  // ****************************************************************
  // AXI4-Lite handshakes
  // ****************************************************************
  // Address and data are taken in either order; no new one until the response is taken.
  assign awready = !aw_full_r && !bvalid_r;
  assign wready = !w_full_r && !bvalid_r;
  assign fire_w = aw_full_r && w_full_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = !rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // Capture of write address and data.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      waddr_r <= '0;
      wbyte_r <= 8'h00;
      wstrb0_r <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_full_r <= 1'b1;
        waddr_r <= awaddr;
      end else if (fire_w) begin
        aw_full_r <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full_r <= 1'b1;
        wbyte_r <= wdata[7:0];
        wstrb0_r <= wstrb[0];
      end else if (fire_w) begin
        w_full_r <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      bvalid_r <= 1'b0;
      bresp_r <= dma_ctl_pkg::RESP_OKAY;
    end else if (fire_w) begin
      bvalid_r <= 1'b1;
      if (waddr_r == dma_ctl_pkg::ADDR_CTRL || waddr_r == dma_ctl_pkg::ADDR_STATUS ||
          waddr_r == dma_ctl_pkg::ADDR_SOFT) begin
        bresp_r <= dma_ctl_pkg::RESP_OKAY;
      end else begin
        bresp_r <= dma_ctl_pkg::RESP_SLVERR;
      end
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read data; the upper 24 bits read as zero, unmapped reads return zero and an error.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= dma_ctl_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= dma_ctl_pkg::RESP_OKAY;
      unique case (araddr)
        dma_ctl_pkg::ADDR_CTRL: rdata_r <= {24'h00_0000, ctrl_r};
        dma_ctl_pkg::ADDR_STATUS: rdata_r <= {24'h00_0000, stat_r[7:NC], dif.flag};
        dma_ctl_pkg::ADDR_SOFT: rdata_r <= {24'h00_0000, soft_r};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= dma_ctl_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Registers written by software
  // ****************************************************************
  // A software write to the control register wins over a hardware run clear in the
  // same cycle, so a re-enable is never lost.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_r <= dma_ctl_pkg::CTRL_RST;
    end else if (fire_w && wstrb0_r && waddr_r == dma_ctl_pkg::ADDR_CTRL) begin
      ctrl_r <= wbyte_r;
    end else begin
      for (int c = 0; c < NC; c++) begin
        if (hw_run_clr[c]) begin
          ctrl_r[dma_ctl_pkg::RUN_POS0 + dma_ctl_pkg::CH_STRIDE * c] <= 1'b0;
        end
      end
    end
  end

  // Priority, loop and wait bits; the done bits live in the flag bank.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      stat_r <= dma_ctl_pkg::STATUS_RST;
    end else if (fire_w && wstrb0_r && waddr_r == dma_ctl_pkg::ADDR_STATUS) begin
      stat_r <= {wbyte_r[7:NC], {NC{1'b0}}};
    end
  end

  // Software requests; a non-loop block end drops its bit unless software sets it again.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      soft_r <= dma_ctl_pkg::SOFT_RST;
    end else if (fire_w && wstrb0_r && waddr_r == dma_ctl_pkg::ADDR_SOFT) begin
      soft_r <= wbyte_r;
    end else begin
      soft_r <= soft_r & ~soft_clr;
    end
  end

  // ****************************************************************
  // Done flags
  // ****************************************************************
  assign dif.set = done_set;
  assign dif.rd_arm = arvalid && arready && araddr == dma_ctl_pkg::ADDR_STATUS;
  assign dif.wr = fire_w && wstrb0_r && waddr_r == dma_ctl_pkg::ADDR_STATUS;
  assign dif.wdata = wbyte_r[NC-1:0];
  assign dma_irq = |(dif.flag & irq_en);

  done_flag_bank #(.N(NC)) u_flags (
    .clock(clock),
    .rstn(rstn),
    .dif(dif)
  );

  // ****************************************************************
  // Service request synchroniser
  // ****************************************************************
  // Three stages; a change is accepted only once the last two stages agree.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      periph_r <= '0;
    end else begin
      sync1_r <= periph_req;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int s = 0; s < NS; s++) begin
        if (sync2_r[s] == sync3_r[s]) begin
          periph_r[s] <= sync3_r[s];
        end
      end
    end
  end

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  // Software bit n stands in for source code n.
  assign req_all = periph_r | soft_r;

  // Pending channels and a fixed ranking with channel 0 first.
  always_comb begin
    pick = '0;
    for (int c = 0; c < NC; c++) begin
      pending[c] = run[c] && req_all[transfer_source_select[c]];
    end
    for (int c = NC - 1; c >= 0; c--) begin
      if (pending[c]) begin
        pick = NC'(1) << c;
      end
    end
  end

  // With priority zero a waiting CPU interrupt outranks every channel.
  assign hold = (cpu_wait && !wait_en) || ((cpu_irq_req || susp_r) && !prio);
  assign unit_end = state_r == ST_MOVE && cyc_r == 4'h0;
  assign may_start = state_r == ST_IDLE || (state_r == ST_GAP && cyc_r == 4'h0) ||
                     (unit_end && gap == 4'h0);

  // Block end check and CPU share after the unit ending now.
  always_comb begin
    blk_end = 1'b0;
    for (int c = 0; c < NC; c++) begin
      if (active_r[c]) begin
        blk_end = 8'(chan_byte_count[c] + (chan_word_mode[c] ? dma_ctl_pkg::WORD_LEN :
                  dma_ctl_pkg::BYTE_LEN)) == chan_block_length[c];
      end
    end
    unique case (ctrl_r[dma_ctl_pkg::BW_HI_POS:dma_ctl_pkg::BW_LO_POS])
      dma_ctl_pkg::BW_25: gap = dma_ctl_pkg::GAP_25;
      dma_ctl_pkg::BW_50: gap = dma_ctl_pkg::GAP_50;
      dma_ctl_pkg::BW_67: gap = dma_ctl_pkg::GAP_67;
      dma_ctl_pkg::BW_100: gap = dma_ctl_pkg::GAP_100;
    endcase
    if (blk_end && gap < dma_ctl_pkg::MIN_CPU_GAP) begin
      gap = dma_ctl_pkg::MIN_CPU_GAP;
    end
  end

  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  // A byte holds the bus for two cycles, a word for four; the bus is never split
  // inside a unit, which bounds the extra interrupt latency.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      cyc_r <= 4'h0;
      active_r <= '0;
    end else if (may_start && |pending && !hold) begin
      state_r <= ST_MOVE;
      active_r <= pick;
      cyc_r <= 4'h0;
      for (int c = 0; c < NC; c++) begin
        if (pick[c]) begin
          cyc_r <= (chan_word_mode[c] ? dma_ctl_pkg::WORD_CYC : dma_ctl_pkg::BYTE_CYC) - 4'h1;
        end
      end
    end else if (unit_end) begin
      active_r <= '0;
      if (gap == 4'h0) begin
        state_r <= ST_IDLE;
      end else begin
        state_r <= ST_GAP;
        cyc_r <= gap - 4'h1;
      end
    end else if (state_r == ST_GAP && cyc_r == 4'h0) begin
      state_r <= ST_IDLE;
    end else if (state_r != ST_IDLE) begin
      cyc_r <= cyc_r - 4'h1;
    end
  end

  // Datapath strobes, one cycle after the last bus cycle of a unit.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      step_r <= '0;
      clear_r <= '0;
    end else begin
      step_r <= unit_end ? active_r : '0;
      clear_r <= (unit_end && blk_end) ? active_r : '0;
    end
  end

  assign chan_active = active_r;
  assign chan_step = step_r;
  assign chan_count_clear = clear_r;
  assign dma_bus_own = state_r == ST_MOVE;

  // Completion events and the run and software bits they stop.
  always_comb begin
    done_set = '0;
    hw_run_clr = '0;
    soft_clr = '0;
    for (int c = 0; c < NC; c++) begin
      if (unit_end && blk_end && active_r[c]) begin
        done_set[c] = 1'b1;
        if (!loop_en[c]) begin
          hw_run_clr[c] = 1'b1;
          soft_clr[transfer_source_select[c]] = 1'b1;
        end
      end
      if ((ack_r && !prio) || (wait_d_r && !cpu_wait && susp_r && !prio)) begin
        hw_run_clr[c] = hw_run_clr[c] | pending[c];
      end
    end
  end

  // ****************************************************************
  // CPU interrupt recognition
  // ****************************************************************
  // Priority zero waits only for the unit on the bus; priority one waits until no
  // channel has anything left to move.
  assign recog = prio ? (state_r != ST_MOVE && !(|pending)) : (state_r != ST_MOVE);
  assign cpu_irq_ack = ack_r;

  // The acknowledge is a single pulse; the CPU drops its request after it.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= cpu_irq_req && recog && !ack_r;
    end
  end

  // ****************************************************************
  // Wait mode tracking
  // ****************************************************************
  // Remember that a transfer was held off so its fate is settled when wait ends.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wait_d_r <= 1'b0;
      susp_r <= 1'b0;
    end else begin
      wait_d_r <= cpu_wait;
      if (cpu_wait && !wait_en && |pending) begin
        susp_r <= 1'b1;
      end else if (!cpu_wait) begin
        susp_r <= 1'b0;
      end
    end
  end

endmodule : dma_control_status_logic

// file: core/dma_ctl_pkg.sv
// Shared constants for the DMA control and status logic.
package dma_ctl_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_CH = 3; // Number of DMA channels.
  localparam int NUM_SRC = 8; // Number of transfer sources.
  localparam int ADDR_W = 12; // AXI byte address width decoded by the slave.

  // ****************************************************************
  // Register indices and byte addresses (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_CTRL = 8'h4C;
  localparam logic [7:0] IDX_STATUS = 8'h4D;
  localparam logic [7:0] IDX_SOFT = 8'h4E;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SOFT = {2'h0, IDX_SOFT, 2'h0};

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] SOFT_RST = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BW_HI_POS = 7; // Bandwidth select, upper bit.
  localparam int BW_LO_POS = 6; // Bandwidth select, lower bit.
  localparam int RUN_POS0 = 1; // Run bit of channel 0; channel n sits 2n above.
  localparam int IRQEN_POS0 = 0; // Interrupt enable of channel 0; channel n sits 2n above.
  localparam int CH_STRIDE = 2; // Distance between fields of adjacent channels.
  localparam int PRIO_POS = 7; // Interrupt priority select.
  localparam int LOOP_POS0 = 4; // Loop enable of channel 0; channel n sits n above.
  localparam int WAITEN_POS = 3; // Wait operation enable.
  localparam int DONE_POS0 = 0; // Done flag of channel 0; channel n sits n above.

  // ****************************************************************
  // Bandwidth codes and CPU cycles granted after each DMA unit
  // ****************************************************************
  localparam logic [1:0] BW_25 = 2'h0;
  localparam logic [1:0] BW_50 = 2'h1;
  localparam logic [1:0] BW_67 = 2'h2;
  localparam logic [1:0] BW_100 = 2'h3;
  localparam logic [3:0] GAP_25 = 4'h6;
  localparam logic [3:0] GAP_50 = 4'h2;
  localparam logic [3:0] GAP_67 = 4'h1;
  localparam logic [3:0] GAP_100 = 4'h0;
  localparam logic [3:0] MIN_CPU_GAP = 4'h1; // Forced CPU cycles at a block end.

  // ****************************************************************
  // Transfer unit lengths in bus cycles and bytes
  // ****************************************************************
  localparam logic [3:0] BYTE_CYC = 4'h2;
  localparam logic [3:0] WORD_CYC = 4'h4;
  localparam logic [7:0] BYTE_LEN = 8'h01;
  localparam logic [7:0] WORD_LEN = 8'h02;

  // ****************************************************************
  // AXI responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : dma_ctl_pkg

// file: core/done_flag_if.sv
// Signals between the control logic and the done flag bank.
interface done_flag_if #(
  parameter int N = 3
);
  logic [N-1:0] set; // One-cycle completion events.
  logic rd_arm; // Status register read accepted.
  logic wr; // Status register write accepted.
  logic [N-1:0] wdata; // Written flag values.
  logic [N-1:0] flag; // Current flag values.

  modport bank (input set, input rd_arm, input wr, input wdata, output flag);
  modport ctl (output set, output rd_arm, output wr, output wdata, input flag);
endinterface : done_flag_if

// file: core/done_flag_bank.sv
// Sticky completion flags with a read-then-write-zero clear.
module done_flag_bank #(
  parameter int N = 3
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Flag traffic.
  done_flag_if.bank dif
);

  logic [N-1:0] flag_r; // Flag state.
  logic [N-1:0] armed_r; // Flag was read while set, so a zero write may clear it.

  assign dif.flag = flag_r;

  // ****************************************************************
  // Flag state
  // ****************************************************************
  // A completion in the same cycle as a clearing write keeps the flag set.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      flag_r <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (dif.set[i]) begin
          flag_r[i] <= 1'b1;
        end else if (dif.wr && !dif.wdata[i] && armed_r[i]) begin
          flag_r[i] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Arming by a read
  // ****************************************************************
  // Any status register write ends the read-then-write pair, whatever it wrote.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      armed_r <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (dif.rd_arm && flag_r[i]) begin
          armed_r[i] <= 1'b1;
        end else if (dif.wr) begin
          armed_r[i] <= 1'b0;
        end
      end
    end
  end

endmodule : done_flag_bank

// file: dv/dma_csl_asserts.sv
// Port-level assertions for the DMA control and status logic.
module dma_csl_asserts (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Watched ports.
  input wire logic [dma_ctl_pkg::NUM_CH-1:0] chan_active,
  input wire logic [dma_ctl_pkg::NUM_CH-1:0] chan_step,
  input wire logic [dma_ctl_pkg::NUM_CH-1:0] chan_count_clear,
  input wire logic [dma_ctl_pkg::NUM_CH-1:0] chan_word_mode,
  input wire logic dma_bus_own,
  input wire logic cpu_irq_req,
  input wire logic cpu_irq_ack,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_one; $onehot0(chan_active); endproperty
  a_one: assert property (p_one) else $error("two channels on the bus");
  property p_own; |chan_active |-> dma_bus_own; endproperty
  a_own: assert property (p_own) else $error("channel active without bus");
  property p_unit;
    $rose(chan_active[0]) && !chan_word_mode[0] |-> ##1 chan_active[0] ##1 chan_step[0];
  endproperty
  a_unit: assert property (p_unit) else $error("byte unit not two cycles");
  property p_clr; (chan_count_clear & ~chan_step) == 3'h0; endproperty
  a_clr: assert property (p_clr) else $error("count clear without step");
  property p_ackbus; cpu_irq_ack |-> !(|chan_active); endproperty
  a_ackbus: assert property (p_ackbus) else $error("ack during unit");
  property p_ackreq; cpu_irq_ack |-> $past(cpu_irq_req); endproperty
  a_ackreq: assert property (p_ackreq) else $error("ack without request");
  property p_ackpulse; cpu_irq_ack |=> !cpu_irq_ack; endproperty
  a_ackpulse: assert property (p_ackpulse) else $error("ack longer than one cycle");
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule : dma_csl_asserts
bind dma_control_status_logic dma_csl_asserts u_chk (.*);

// file: dv/dp_model.sv
// Channel byte counter model standing in for the datapath.
module dp_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [2:0] chan_step,
  input wire logic [2:0] chan_count_clear,
  input wire logic [2:0] chan_word_mode,
  output logic [2:0][7:0] byte_count
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clear beats step, so a loop restarts from base.
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (!rstn || chan_count_clear[i]) byte_count[i] <= 8'h00;
      else if (chan_step[i]) byte_count[i] <= byte_count[i] + (chan_word_mode[i] ? 8'h02 : 8'h01);
    end
  end
endmodule : dp_model

// file: dv/dma_control_status_logic_test.sv
// Register-level test of the DMA control and status logic.
module dma_control_status_logic_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rstn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready;
  logic rvalid, dma_bus_own, cpu_irq_req, cpu_irq_ack, dma_irq, wt;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [2:0] act, stp, clr;
  logic [2:0][7:0] cnt;
  logic [7:0] v;
  logic [1:0] r;
  int n_fail, comparisons, n;
  dma_control_status_logic u_dut (.clock(clock), .rstn(rstn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .periph_req(8'h00), .transfer_source_select({3'h0, 3'h0, 3'h4}),
    .chan_word_mode(3'h0), .chan_byte_count(cnt), .chan_block_length({3{8'h04}}),
    .chan_active(act), .chan_step(stp), .chan_count_clear(clr), .dma_bus_own(dma_bus_own),
    .cpu_irq_req(cpu_irq_req), .cpu_wait(wt), .cpu_irq_ack(cpu_irq_ack), .dma_irq(dma_irq));
  dp_model u_dp (.clock(clock), .rstn(rstn), .chan_step(stp), .chan_count_clear(clr),
    .chan_word_mode(3'h0), .byte_count(cnt));
  // Tasks wait an edge first so no strobe is set twice in one step.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
    forever begin
      @(posedge clock);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    araddr <= a; arvalid <= 1; rready <= 1;
    forever begin
      @(posedge clock);
      if (arready) arvalid <= 0;
      if (rvalid) begin v = rdata[7:0]; r = rresp; break; end
    end
    rready <= 0;
  endtask : rd
  task automatic chk(input string nm, input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin n_fail++; $display("Error %s expected %h seen %h", nm, e, g); end
  endtask : chk
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic wait_done;
    repeat (100) begin rd(dma_ctl_pkg::ADDR_STATUS); if (v[0]) break; end
  endtask : wait_done
  initial begin clock = 0; forever #2.5 clock = ~clock; end
  initial begin repeat (20000) @(posedge clock); n_fail++; stop_test(); end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, cpu_irq_req, wt} = 0;
    {awaddr, araddr, wdata} = 0;
    repeat (5) @(posedge clock);
    rstn <= 1;
    rd(dma_ctl_pkg::ADDR_CTRL); chk("ctrl", v, 8'h00);
    rd(dma_ctl_pkg::ADDR_STATUS); chk("status", v, 8'h00);
    rd(dma_ctl_pkg::ADDR_SOFT); chk("soft", v, 8'h00);
    rd(12'h000); chk("resp", 8'(r), 8'(dma_ctl_pkg::RESP_SLVERR));
    wr(dma_ctl_pkg::ADDR_CTRL, 8'hC2); wr(dma_ctl_pkg::ADDR_SOFT, 8'h10);
    rd(dma_ctl_pkg::ADDR_SOFT); chk("soft busy", v, 8'h10);
    wait_done(); chk("done", v, 8'h01);
    chk("count", cnt[0], 8'h00);
    rd(dma_ctl_pkg::ADDR_CTRL); chk("run off", v, 8'hC0);
    rd(dma_ctl_pkg::ADDR_SOFT); chk("soft end", v, 8'h00);
    wr(dma_ctl_pkg::ADDR_CTRL, 8'h01); chk("irq", 8'(dma_irq), 8'h01);
    wr(dma_ctl_pkg::ADDR_STATUS, 8'h01); wr(dma_ctl_pkg::ADDR_STATUS, 8'h00);
    rd(dma_ctl_pkg::ADDR_STATUS); chk("no read", v, 8'h01);
    wr(dma_ctl_pkg::ADDR_STATUS, 8'h00); rd(dma_ctl_pkg::ADDR_STATUS); chk("clr", v, 8'h00);
    chk("irq off", 8'(dma_irq), 8'h00);
    wr(dma_ctl_pkg::ADDR_STATUS, 8'h10); wr(dma_ctl_pkg::ADDR_CTRL, 8'hC2);
    wr(dma_ctl_pkg::ADDR_SOFT, 8'h10); wait_done();
    rd(dma_ctl_pkg::ADDR_CTRL); chk("loop run", v, 8'hC2);
    cpu_irq_req <= 1; n = 0;
    do begin @(posedge clock); n++; end while (cpu_irq_ack !== 1'b1 && n < 50);
    cpu_irq_req <= 0;
    chk("latency", 8'(n <= 4), 8'h01);
    rd(dma_ctl_pkg::ADDR_CTRL); chk("irq run", v, 8'hC0);
    wt <= 1; wr(dma_ctl_pkg::ADDR_CTRL, 8'hC2);
    wt <= 0; rd(dma_ctl_pkg::ADDR_CTRL); chk("wait", v, 8'hC0);
    stop_test();
  end
endmodule : dma_control_status_logic_test
